// File: ims_ctrl.sv
`timescale 1ns/1ns
module ims_ctrl
  import ims_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic [ims_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ims_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ims_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  output logic                           irq
);
  import ims_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_LOW, M_STOP_HIGH} ims_mst_e;

  initial
  begin
    if (HALF_CYC < 2 || HALF_CYC >= (1 << CNT_W))
      $error("ims_ctrl: HALF_CYC out of range");
  end

  // ---------------------------------------------------------------
  // Pin sampling and bus conditions
  // ---------------------------------------------------------------
  logic [1:0]       pins_s;
  logic             scl_s;
  logic             sda_s;
  logic             scl_d_reg;
  logic             sda_d_reg;

  ims_sync #(.WIDTH(2)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .din      ({scl_in, sda_in}),
    .dout     (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic             stop_reg;
  logic             bus_busy_flag_reg, mst_reg, trs_reg, trs_eff_reg, trs_pend_reg, ack_check_enable_reg;
  logic             iflag_reg, al_reg, aas_reg, received_ack_bit_reg, dre_reg, wait_en_reg;
  logic [7:0]       data_reg, own1_reg, own2_reg, shreg;
  logic [1:0]       compat_reg;
  logic [IRQ_N-1:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic [3:0]       nbit_reg;
  logic             addr_frame_reg, slave_sel_reg, hold_reg, eng_low_reg;
  logic             wait_reg, win78_reg, clr_pend_reg, win_a_reg, stop_pend_reg;
  ims_mst_e         mstate;
  logic [CNT_W-1:0] cnt_reg;

  // ---------------------------------------------------------------
  // Decode and events
  // ---------------------------------------------------------------
  logic acc, wr_ctl, wr_data, rd_data, compat_off, part, tx_now, match;
  logic scl_rise, scl_fall, start_det, stop_det, rise9, fall7, fall8;
  logic al_evt, addr_hit, spurious, data_done, nack_evt, wait_ins;
  logic iflag_set, iflag_clr, stop_cmd, start_cmd, rel_hold, cnt_done;

  assign acc        = ~stop_reg;
  assign wr_ctl     = reg_wr & acc & (reg_addr == ADDR_CONTROL);
  assign wr_data    = reg_wr & acc & (reg_addr == ADDR_DATA);
  assign rd_data    = reg_rd & acc & (reg_addr == ADDR_DATA);
  assign compat_off = (compat_reg == COMPAT_ALL);
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_det  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign part       = mst_reg | slave_sel_reg | addr_frame_reg;
  assign tx_now     = mst_reg ? trs_eff_reg : (slave_sel_reg & ~addr_frame_reg & trs_eff_reg);
  assign match      = (shreg[7:1] == own1_reg[7:1]) | (shreg[7:1] == own2_reg[7:1]);
  assign rise9      = scl_rise & (nbit_reg == 4'h8) & part;
  assign fall7      = scl_fall & (nbit_reg == 4'h7);
  assign fall8      = scl_fall & (nbit_reg == 4'h8);
  assign al_evt     = scl_rise & mst_reg & tx_now & (nbit_reg < 4'h8) & ~eng_low_reg & ~sda_s;
  assign addr_hit   = rise9 & addr_frame_reg & match;
  assign spurious   = rise9 & addr_frame_reg & ~match & received_ack_bit_reg & trs_eff_reg & ~compat_off;
  assign data_done  = rise9 & ~addr_frame_reg;
  assign nack_evt   = data_done & tx_now & sda_s;
  assign wait_ins   = fall8 & mst_reg & wait_en_reg;
  assign iflag_set  = data_done | addr_hit | spurious | wait_ins;
  assign iflag_clr  = wr_ctl & ~reg_wdata[CTL_IFLAG] & iflag_reg;
  assign stop_cmd   = wr_ctl & ~reg_wdata[CTL_BUS_BUSY_FLAG] & ~reg_wdata[CTL_SCP] & mst_reg & bus_busy_flag_reg;
  assign start_cmd  = wr_ctl & reg_wdata[CTL_BUS_BUSY_FLAG] & ~reg_wdata[CTL_SCP] & reg_wdata[CTL_MST]
                      & ~bus_busy_flag_reg & (mstate == M_IDLE);
  assign rel_hold   = hold_reg & ((wr_data & tx_now) | (rd_data & ~tx_now) | stop_cmd);
  assign cnt_done   = (cnt_reg == CNT_W'(HALF_CYC - 1));
  assign irq_set    = {nack_evt, stop_det & acc, al_evt, iflag_set};

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stop_reg     <= STOP_RESET;
      own1_reg     <= OWN_RESET;
      own2_reg     <= OWN_RESET;
      compat_reg   <= COMPAT_RESET;
      wait_en_reg  <= 1'b0;
      ack_check_enable_reg     <= 1'b0;
      irq_mask_reg <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == ADDR_POWER)
        stop_reg <= reg_wdata[0];
      if (reg_wr && acc)
      begin
        case (reg_addr)
          ADDR_OWN1:     own1_reg     <= reg_wdata;
          ADDR_OWN2:     own2_reg     <= reg_wdata;
          ADDR_EXT:      compat_reg   <= reg_wdata[1:0];
          ADDR_MODE:     wait_en_reg  <= reg_wdata[MODE_WAIT];
          ADDR_CONTROL:  ack_check_enable_reg     <= reg_wdata[CTL_ACK_CHECK_ENABLE];
          ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata[IRQ_N-1:0];
          default:       ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode, bus busy and direction
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || stop_reg)
    begin
      mst_reg      <= 1'b0;
      bus_busy_flag_reg     <= 1'b0;
      trs_reg      <= 1'b0;
      trs_eff_reg  <= 1'b0;
      trs_pend_reg <= 1'b0;
      win_a_reg    <= 1'b1;
    end
    else
    begin
      if (start_det)
        bus_busy_flag_reg <= 1'b1;
      else if (stop_det)
        bus_busy_flag_reg <= 1'b0;
      if (rise9 || stop_det)
        win_a_reg <= 1'b1;
      else if (scl_rise)
        win_a_reg <= 1'b0;
      if (al_evt)
      begin
        mst_reg      <= 1'b0;
        trs_reg      <= 1'b0;
        trs_eff_reg  <= 1'b0;
        trs_pend_reg <= 1'b0;
      end
      else if (wr_ctl)
      begin
        mst_reg <= reg_wdata[CTL_MST];
        trs_reg <= reg_wdata[CTL_DIR];
        if (reg_wdata[CTL_MST] || win_a_reg || compat_off)
        begin
          trs_eff_reg  <= reg_wdata[CTL_DIR];
          trs_pend_reg <= 1'b0;
        end
        else
          trs_pend_reg <= 1'b1;
      end
      else if (addr_hit)
      begin
        trs_eff_reg  <= shreg[0];
        trs_reg      <= shreg[0];
        trs_pend_reg <= 1'b0;
      end
      else if ((rise9 || stop_det) && trs_pend_reg)
      begin
        trs_eff_reg  <= trs_reg;
        trs_pend_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || stop_reg)
    begin
      iflag_reg <= 1'b0;
      al_reg    <= 1'b0;
      aas_reg   <= 1'b0;
      received_ack_bit_reg  <= 1'b0;
      dre_reg   <= 1'b0;
    end
    else
    begin
      if (iflag_set)
        iflag_reg <= 1'b1;
      else if (iflag_clr)
        iflag_reg <= 1'b0;
      if (al_evt)
        al_reg <= 1'b1;
      else if (reg_wr && reg_addr == ADDR_STATUS && !reg_wdata[ST_AL])
        al_reg <= 1'b0;
      if (addr_hit)
        aas_reg <= 1'b1;
      else if (start_det || stop_det)
        aas_reg <= 1'b0;
      if (data_done && tx_now && ack_check_enable_reg)
        received_ack_bit_reg <= sda_s;
      // clearing ack check resets received bit
      else if (wr_ctl && !reg_wdata[CTL_ACK_CHECK_ENABLE])
        received_ack_bit_reg <= 1'b0;
      if (data_done && tx_now)
        dre_reg <= 1'b1;
      else if (wr_data)
        dre_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Wait after 8th clock
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || stop_reg)
    begin
      wait_reg     <= 1'b0;
      win78_reg    <= 1'b0;
      clr_pend_reg <= 1'b0;
    end
    else
    begin
      if (fall7)
        win78_reg <= 1'b1;
      else if (fall8)
        win78_reg <= 1'b0;
      if (fall8)
        clr_pend_reg <= 1'b0;
      else if (iflag_clr && win78_reg && mst_reg && wait_en_reg && !compat_off)
        clr_pend_reg <= 1'b1;
      // insert wait, released by flag clear
      if (wait_ins)
        wait_reg <= ~clr_pend_reg;
      else if (iflag_clr || !mst_reg)
        wait_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || stop_reg)
    begin
      nbit_reg       <= 4'h0;
      shreg          <= 8'h00;
      data_reg       <= 8'h00;
      addr_frame_reg <= 1'b0;
      slave_sel_reg  <= 1'b0;
      hold_reg       <= 1'b0;
      eng_low_reg    <= 1'b0;
    end
    else
    begin
      if (wr_data)
        data_reg <= reg_wdata;
      else if (data_done && !tx_now)
        data_reg <= shreg;
      if (start_det)
      begin
        nbit_reg       <= 4'h0;
        eng_low_reg    <= 1'b0;
        addr_frame_reg <= ~mst_reg;
        slave_sel_reg  <= 1'b0;
        hold_reg       <= mst_reg;
      end
      else if (stop_det)
      begin
        nbit_reg       <= 4'h0;
        eng_low_reg    <= 1'b0;
        addr_frame_reg <= 1'b0;
        slave_sel_reg  <= 1'b0;
        hold_reg       <= 1'b0;
      end
      else if (al_evt)
      begin
        addr_frame_reg <= 1'b1;
        eng_low_reg    <= 1'b0;
        hold_reg       <= 1'b0;
        nbit_reg       <= nbit_reg + 4'h1;
        shreg          <= {shreg[6:0], sda_s};
      end
      else if (rel_hold)
      begin
        // data access ends stretch
        // Ahead of SCL edges so a same-cycle access is not lost to them; start, stop and arbitration loss still win
        hold_reg <= 1'b0;
        if (wr_data && tx_now)
        begin
          shreg       <= reg_wdata;
          eng_low_reg <= ~reg_wdata[7];
        end
      end
      else if (scl_rise && part)
      begin
        nbit_reg <= nbit_reg + 4'h1;
        if (nbit_reg < 4'h8)
          shreg <= {shreg[6:0], sda_s};
        if (rise9 && addr_frame_reg)
        begin
          addr_frame_reg <= 1'b0;
          slave_sel_reg  <= match;
        end
      end
      else if (scl_fall && part)
      begin
        if (nbit_reg == 4'h9)
        begin
          nbit_reg    <= 4'h0;
          eng_low_reg <= 1'b0;
          hold_reg    <= 1'b1;
        end
        else if (nbit_reg == 4'h8)
        begin
          if (addr_frame_reg)
            eng_low_reg <= match & ~trs_eff_reg & ~mst_reg;
          else
            eng_low_reg <= ~tx_now;
        end
        else
          eng_low_reg <= tx_now & ~shreg[7];
      end
      else if (!part)
        hold_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Master clock generator
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || stop_reg)
    begin
      mstate        <= M_IDLE;
      cnt_reg       <= '0;
      stop_pend_reg <= 1'b0;
    end
    else
    begin
      if (stop_cmd)
        stop_pend_reg <= 1'b1;
      else if (mstate == M_STOP_LOW)
        stop_pend_reg <= 1'b0;
      cnt_reg <= cnt_done ? cnt_reg : cnt_reg + CNT_W'(1);
      case (mstate)
        M_IDLE:
        begin
          cnt_reg <= '0;
          if (start_cmd)
            mstate <= M_START;
        end
        M_START:
          if (cnt_done)
          begin
            mstate  <= M_LOW;
            cnt_reg <= '0;
          end
        M_LOW:
          if (!mst_reg)
            mstate <= M_IDLE;
          else if (cnt_done && stop_pend_reg)
          begin
            mstate  <= M_STOP_LOW;
            cnt_reg <= '0;
          end
          else if (cnt_done && !hold_reg && !wait_reg)
          begin
            mstate  <= M_HIGH;
            cnt_reg <= '0;
          end
        M_HIGH:
          if (!mst_reg)
            mstate <= M_IDLE;
          else if (!scl_s)
            cnt_reg <= '0;
          else if (cnt_done)
          begin
            mstate  <= M_LOW;
            cnt_reg <= '0;
          end
        M_STOP_LOW:
          if (cnt_done)
          begin
            mstate  <= M_STOP_HIGH;
            cnt_reg <= '0;
          end
        M_STOP_HIGH:
          if (!scl_s)
            cnt_reg <= '0;
          else if (cnt_done)
            mstate <= M_IDLE;
        default:
          mstate <= M_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || stop_reg)
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= (mstate == M_LOW) | (mstate == M_STOP_LOW)
                 | (hold_reg & ~mst_reg & slave_sel_reg & ~scl_s);
      sda_oe  <= (mstate == M_START) | (mstate == M_STOP_LOW)
                 | (mstate == M_STOP_HIGH) | (eng_low_reg & (mstate != M_IDLE | ~mst_reg));
    end
  end

  // ---------------------------------------------------------------
  // Interrupts and read data
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
      reg_rdata    <= 8'h00;
    end
    else
    begin
      if (reg_rd && acc && reg_addr == ADDR_IRQ_STAT)
        irq_stat_reg <= irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
      irq       <= |(irq_stat_reg & irq_mask_reg);
      reg_rdata <= 8'h00;
      if (reg_rd && reg_addr == ADDR_POWER)
        reg_rdata <= {7'h00, stop_reg};
      else if (reg_rd && acc)
      begin
        case (reg_addr)
          ADDR_CONTROL:  reg_rdata <= {2'b00, bus_busy_flag_reg, 1'b1, mst_reg, trs_reg,
                                       ack_check_enable_reg, iflag_reg};
          ADDR_STATUS:   reg_rdata <= {4'h0, al_reg, aas_reg, dre_reg, received_ack_bit_reg};
          ADDR_DATA:     reg_rdata <= data_reg;
          ADDR_MODE:     reg_rdata <= {1'b0, wait_en_reg, 3'b000,
                                       (nbit_reg >= 4'h8) ? 3'h0 : 3'(4'h8 - nbit_reg)};
          ADDR_OWN1:     reg_rdata <= own1_reg;
          ADDR_OWN2:     reg_rdata <= own2_reg;
          ADDR_EXT:      reg_rdata <= {6'h00, compat_reg};
          ADDR_IRQ_STAT: reg_rdata <= {4'h0, irq_stat_reg};
          ADDR_IRQ_MASK: reg_rdata <= {4'h0, irq_mask_reg};
          default:       reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// File: ims_pkg.sv
// Operation
// - Master with waiting on: hold SCL after 8th fall until flag cleared
// - Flag cleared between 7th and 8th fall is kept; wait ends at once
// - Slave direction write applies now in window, else at 9th rise or stop
// - Restart with transmit still effective: address gets no acknowledge
// - Arbitration loss: go slave receive, treat frame as address
// - Stale not-acknowledge may raise flag on unmatched address
// - Compatibility field at 11 removes the timing hazards
// - Halted after reset; registers reachable once module stop cleared
// - Bus busy and command bit both written 0: generate stop
package ims_pkg;

  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  ADDR_STATUS   = 4'h1;
  localparam logic [3:0]  ADDR_DATA     = 4'h2;
  localparam logic [3:0]  ADDR_MODE     = 4'h3;
  localparam logic [3:0]  ADDR_OWN1     = 4'h4;
  localparam logic [3:0]  ADDR_OWN2     = 4'h5;
  localparam logic [3:0]  ADDR_EXT      = 4'h6;
  localparam logic [3:0]  ADDR_POWER    = 4'h7;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h9;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          CTL_IFLAG     = 0;
  localparam int          CTL_ACK_CHECK_ENABLE      = 1;
  localparam int          CTL_DIR       = 2;
  localparam int          CTL_MST       = 3;
  localparam int          CTL_SCP       = 4;
  localparam int          CTL_BUS_BUSY_FLAG      = 5;
  localparam int          ST_RECEIVED_ACK_BIT       = 0;
  localparam int          ST_DRE        = 1;
  localparam int          ST_AAS        = 2;
  localparam int          ST_AL         = 3;
  localparam int          MODE_WAIT     = 6;
  localparam int          IRQ_FRAME     = 0;
  localparam int          IRQ_AL        = 1;
  localparam int          IRQ_STOP      = 2;
  localparam int          IRQ_NACK      = 3;
  localparam int          IRQ_N         = 4;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0]  OWN_RESET     = 8'h00;
  localparam logic [1:0]  COMPAT_RESET  = 2'h0;
  localparam logic [1:0]  COMPAT_ALL    = 2'h3;
  localparam logic        STOP_RESET    = 1'b1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SCL_HALF_NS   = 5000;
  localparam int          SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 16;

endpackage

// File: ims_sync.sv
`timescale 1ns/1ns
module ims_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  initial
  begin
    if (WIDTH < 1)
      $error("ims_sync: WIDTH must be at least 1");
  end

  // Two stages; first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      meta_reg <= '1;
      dout     <= '1;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

// File: ims_chk.sv
`timescale 1ns/1ns
module ims_chk
  import ims_pkg::*;
(
  input wire logic                       core_clk,
  input wire logic                       reset,
  input wire logic [ims_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ims_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [ims_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       scl_out,
  input wire logic                       scl_oe,
  input wire logic                       sda_out,
  input wire logic                       sda_oe,
  input wire logic                       irq
);
  import ims_pkg::*;
  logic       stop_reg;
  logic [3:0] mask_reg;
  always_ff @(posedge core_clk)
    if (reset)
      stop_reg <= 1'b1;
    else if (reg_wr && reg_addr == ADDR_POWER)
      stop_reg <= reg_wdata[0];
  always_ff @(posedge core_clk)
    if (reset)
      mask_reg <= 4'h0;
    else if (reg_wr && !stop_reg && reg_addr == ADDR_IRQ_MASK)
      mask_reg <= reg_wdata[3:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_STOP_READ: assert property (
    stop_reg && reg_rd && reg_addr != ADDR_POWER |=> reg_rdata == 8'h00) else $error("stopped read");
  AST_STOP_PINS: assert property (
    stop_reg |-> !scl_oe && !sda_oe && !irq) else $error("stopped drive");
  AST_POWER_RB: assert property (
    reg_rd && reg_addr == ADDR_POWER |=> reg_rdata[0] == $past(stop_reg)) else $error("power bit");
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  AST_RD_UNMAP: assert property (
    reg_rd && reg_addr > ADDR_IRQ_MASK |=> reg_rdata == 8'h00) else $error("unmapped read");
  AST_OPEN_DRAIN: assert property (
    !scl_out && !sda_out) else $error("pin driven high");
  AST_SCL_LOW: assert property (
    $rose(scl_oe) |-> scl_oe [*3]) else $error("short low phase");
  AST_IRQ_MASK: assert property (
    mask_reg == 4'h0 && $past(mask_reg) == 4'h0 |-> !irq) else $error("masked irq");
endmodule
bind ims_ctrl ims_chk i_ims_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// File: ims_peer.sv
`timescale 1ns/1ns
module ims_peer (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_pull
);
  int n = 0;
  initial sda_pull = 1'b0;
  // Start condition restarts the count
  always @(negedge sda)
    if (scl)
      n = -1;
  // Acknowledge during every ninth clock
  always @(negedge scl)
  begin
    n = n % 9 + 1;
    sda_pull <= (n == 8);
  end
endmodule

// File: ims_ctrl_tb.sv
`timescale 1ns/1ns
module ims_ctrl_tb;
  import ims_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} ims_row_s;
  logic              core_clk, reset, reg_wr, reg_rd, peer_pull;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, q;
  logic              scl_out, scl_oe, sda_out, sda_oe, irq;
  logic [8:0]        sh;
  wire               scl = !scl_oe;
  wire               sda = !(sda_oe || peer_pull);
  int                num_errors, checks, i, num_stops, stops0;
  ims_row_s          rows [8] = '{'{ADDR_OWN1, 8'ha4, 8'ha4}, '{ADDR_OWN2, 8'h5a, 8'h5a},
    '{ADDR_EXT, 8'h03, 8'h03}, '{ADDR_EXT, 8'h00, 8'h00}, '{ADDR_MODE, 8'h40, 8'h40},
    '{ADDR_MODE, 8'h00, 8'h00}, '{4'hc, 8'h55, 8'h00}, '{ADDR_IRQ_MASK, 8'h01, 8'h01}};
  ims_ctrl #(.HALF_CYC(6)) i_ims_ctrl (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  ims_peer i_ims_peer (.scl(scl), .sda(sda), .sda_pull(peer_pull));
  always @(posedge scl)
    sh <= {sh[7:0], sda};
  always @(posedge sda)
    if (scl)
      num_stops++;
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo(input bit ok);
    if (!ok)
    begin
      num_errors++;
      end_sim;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  initial
  begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    reset = 1'b1;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1 chk({5'h0, scl_oe, sda_oe, irq}, 8'h00);
    wr(ADDR_OWN1, 8'hff);
    rd(ADDR_OWN1, q);
    chk(q, 8'h00);
    rd(ADDR_POWER, q);
    chk(q & 8'h01, 8'h01);
    $display("done: stopped");
    wr(ADDR_POWER, 8'h00);
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, q);
      chk(q, rows[k].e);
    end
    $display("done: registers");
    rd(ADDR_CONTROL, q);
    chk(q & 8'h20, 8'h00);
    wr(ADDR_CONTROL, 8'h2c);
    for (i = 0; i < 50 && q[5] !== 1'b1; i++)
      rd(ADDR_CONTROL, q);
    tmo(q[5] === 1'b1);
    wr(ADDR_DATA, 8'ha4);
    for (i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge core_clk);
    tmo(irq === 1'b1);
    chk(sh[8:1], 8'ha4);
    chk({7'h0, sh[0]}, 8'h00);
    rd(ADDR_STATUS, q);
    chk(q & 8'h01, 8'h00);
    chk(q & 8'h08, 8'h00);
    rd(ADDR_IRQ_STAT, q);
    chk(q & 8'h01, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h0, irq}, 8'h00);
    $display("done: frame");
    chk({7'h0, scl}, 8'h00);
    rd(ADDR_MODE, q);
    chk(q & 8'h07, 8'h00);
    rd(ADDR_CONTROL, q);
    chk(q, 8'h3d);
    wr(ADDR_CONTROL, 8'h2c);
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_DATA, 8'h5a);
    for (i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge core_clk);
    tmo(irq === 1'b1);
    rd(ADDR_IRQ_STAT, q);
    chk(q & 8'h01, 8'h01);
    repeat (20) @(posedge core_clk);
    #1 chk({7'h0, scl}, 8'h00);
    chk(sh[7:0], 8'h5a);
    wr(ADDR_CONTROL, 8'h2c);
    for (i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge core_clk);
    tmo(irq === 1'b1);
    chk({7'h0, sh[0]}, 8'h00);
    rd(ADDR_IRQ_STAT, q);
    repeat (12) @(posedge core_clk);
    #1 chk({7'h0, scl}, 8'h00);
    $display("done: wait");
    stops0 = num_stops;
    wr(ADDR_CONTROL, 8'h0c);
    for (i = 0; i < 200 && num_stops == stops0; i++)
      @(posedge core_clk);
    chk(8'(num_stops - stops0), 8'h01);
    repeat (4) @(posedge core_clk);
    #1 chk({7'h0, irq}, 8'h00);
    rd(ADDR_IRQ_STAT, q);
    chk(q & 8'h04, 8'h04);
    $display("done: stop");
    end_sim;
  end
endmodule
